// ### dv/tb_dtp_timer.sv
`timescale 1ns/100ps
module tb_dtp_timer;
    typedef struct packed {
        logic        wr;
        logic [7:0]  addr;
        logic [7:0]  data;
        logic [31:0] exp;
        logic [1:0]  resp;
    } dtp_row_s;
    localparam logic [7:0] A_CNT  = {3'h0, dtp_pkg::IDX_COUNT, 2'h0};
    localparam logic [7:0] A_CT1  = {3'h0, dtp_pkg::IDX_CTRL_ONE, 2'h0};
    localparam logic [7:0] A_CT2  = {3'h0, dtp_pkg::IDX_CTRL_TWO, 2'h0};
    localparam logic [7:0] A_DUTY = {3'h0, dtp_pkg::IDX_DUTY_LOW, 2'h0};
    localparam logic [7:0] A_PS   = {3'h0, dtp_pkg::IDX_PS_COUNT, 2'h0};
    localparam logic [7:0] A_HI   = {3'h0, dtp_pkg::IDX_HIGH_BITS, 2'h0};
    localparam logic [7:0] A_ST   = {3'h0, dtp_pkg::IDX_IRQ_STAT, 2'h0};
    localparam logic [7:0] A_MSK  = {3'h0, dtp_pkg::IDX_IRQ_MASK, 2'h0};
    localparam logic [1:0] OK     = dtp_pkg::RESP_OKAY;
    localparam logic [1:0] ERR    = dtp_pkg::RESP_SLVERR;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic        external_clock_pin = 1'b0;
    logic        gpio_out = 1'b0;
    logic        gpio_oe = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, pwm_port_pin_out, pwm_port_pin_oe, irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [31:0] s_axi_rdata, d;
    int          miscompares = 0;
    int          num_checks = 0;
    int          p;
    dtp_row_s    rows [0:22];

    always #2 clk = ~clk;

    dtp_timer u_dut (
        .clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .external_clock_pin(external_clock_pin), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe), .pwm_port_pin_out(pwm_port_pin_out),
        .pwm_port_pin_oe(pwm_port_pin_oe), .irq(irq));

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic bail(input string nm);
        miscompares++;
        $display("CHECK FAILED %s expected answer seen timeout", nm);
        end_sim();
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [7:0] v,
                             output logic [1:0] rs);
        int   n;
        logic aw_hs, w_hs, b_hs;
        n = 0;
        b_hs = 1'b0;
        rs = 2'h3;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b_hs && n < 100) begin
            @(negedge clk);
            aw_hs = s_axi_awvalid && (s_axi_awready === 1'b1);
            w_hs = s_axi_wvalid && (s_axi_wready === 1'b1);
            b_hs = (s_axi_bvalid === 1'b1);
            rs = s_axi_bresp;
            @(posedge clk);
            if (aw_hs) s_axi_awvalid <= 1'b0;
            if (w_hs) s_axi_wvalid <= 1'b0;
            n++;
        end
        s_axi_bready <= 1'b0;
        if (!b_hs) bail("bvalid");
        @(posedge clk);
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] v,
                            output logic [1:0] rs);
        int   n;
        logic ar_hs, r_hs;
        n = 0;
        r_hs = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!r_hs && n < 100) begin
            @(negedge clk);
            ar_hs = s_axi_arvalid && (s_axi_arready === 1'b1);
            r_hs = (s_axi_rvalid === 1'b1);
            v = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge clk);
            if (ar_hs) s_axi_arvalid <= 1'b0;
            n++;
        end
        s_axi_rready <= 1'b0;
        if (!r_hs) bail("rvalid");
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        axi_write(a, v, r);
        check($sformatf("bresp %h", a), {30'h0, OK}, {30'h0, r});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        axi_read(a, d, r);
        check($sformatf("rdata %h", a), e, d);
    endtask

    task automatic pin_chk(input logic eo, input logic ee);
        repeat (3) @(negedge clk);
        check("pin level", {31'h0, eo}, {31'h0, pwm_port_pin_out});
        check("pin enable", {31'h0, ee}, {31'h0, pwm_port_pin_oe});
        @(posedge clk);
    endtask

    task automatic irq_chk(input logic e);
        @(negedge clk);
        check("irq", {31'h0, e}, {31'h0, irq});
        @(posedge clk);
    endtask

    task automatic ext(input logic v);
        external_clock_pin <= v;
        repeat (6) @(posedge clk);
    endtask

    // Cycles between two rising edges of the pin
    task automatic measure(output int per);
        int   n, t0, rises;
        logic prev;
        prev = 1'b1;
        rises = 0;
        n = 0;
        t0 = 0;
        per = 0;
        while (rises < 2 && n < 20000) begin
            @(negedge clk);
            n++;
            if (pwm_port_pin_out === 1'b1 && !prev) begin
                rises++;
                if (rises == 1) t0 = n;
                else per = n - t0;
            end
            prev = (pwm_port_pin_out === 1'b1);
        end
        if (rises < 2) bail("pwm period");
        @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rows = '{'{0, A_CNT, 0, 0, OK}, '{0, A_CT1, 0, 0, OK},
            '{0, A_CT2, 0, 32'h3F, OK}, '{0, A_DUTY, 0, 0, OK},
            '{0, A_PS, 0, 32'hFF, OK}, '{0, A_HI, 0, 0, OK},
            '{0, A_ST, 0, 0, OK}, '{0, A_MSK, 0, 0, OK},
            '{1, A_CT1, 8'hC6, 0, OK}, '{0, A_CT1, 0, 32'hC6, OK},
            '{1, A_CT1, 8'h00, 0, OK}, '{1, A_CT2, 8'hFF, 0, OK},
            '{0, A_CT2, 0, 32'h3F, OK}, '{1, A_DUTY, 8'hAB, 0, OK},
            '{0, A_DUTY, 0, 0, OK}, '{1, A_HI, 8'h31, 0, OK},
            '{0, A_HI, 0, 32'h31, OK}, '{1, A_HI, 8'h00, 0, OK},
            '{0, 8'h20, 0, 0, ERR}, '{1, 8'h20, 8'h55, 0, ERR},
            '{0, 8'h02, 0, 0, ERR}, '{1, A_MSK, 8'h01, 0, OK},
            '{0, A_MSK, 0, 32'h01, OK}};
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        irq_chk(1'b0);
        for (int i = 0; i < 23; i++) begin
            if (rows[i].wr) begin
                axi_write(rows[i].addr, rows[i].data, r);
            end else begin
                axi_read(rows[i].addr, d, r);
                check("row rdata", rows[i].exp, d);
            end
            check("row resp", {30'h0, rows[i].resp}, {30'h0, r});
        end
        wr(A_CNT, 8'h12);
        wr(A_CT2, 8'h08);
        wr(A_DUTY, 8'h01);
        wr(A_CT1, 8'h83);
        measure(p);
        check("reload period", 32'd19, p);
        wr(A_CT1, 8'h81);
        measure(p);
        check("full scale period", 32'd1024, p);
        wr(A_CNT, 8'h03);
        wr(A_CT1, 8'h83);
        for (int k = 0; k < 8; k++) begin
            wr(A_CT2, 8'h08 | 8'(k));
            wr(A_CT2, 8'(k));
            measure(p);
            check("prescaled period", 4 << (k + 1), p);
        end
        wr(A_CT1, 8'h00);
        wr(A_CNT, 8'h05);
        wr(A_CT2, 8'h28);
        wr(A_CT1, 8'h01);
        ext(1'b1);
        rd(A_CNT, 32'h04);
        ext(1'b0);
        rd(A_CNT, 32'h04);
        wr(A_CT2, 8'h38);
        ext(1'b1);
        rd(A_CNT, 32'h04);
        ext(1'b0);
        rd(A_CNT, 32'h03);
        wr(A_CT1, 8'h00);
        ext(1'b1);
        ext(1'b0);
        rd(A_CNT, 32'h03);
        wr(A_CT1, 8'h01);
        wr(A_CT2, 8'h30);
        axi_read(A_PS, d, r);
        ext(1'b1);
        ext(1'b0);
        rd(A_PS, {24'h0, d[7:0] + 8'h01});
        wr(A_CT1, 8'h00);
        wr(A_ST, 8'h01);
        wr(A_CNT, 8'h04);
        wr(A_CT2, 8'h08);
        wr(A_CT1, 8'h07);
        repeat (20) @(posedge clk);
        rd(A_CNT, 32'h00);
        rd(A_ST, 32'h01);
        irq_chk(1'b1);
        wr(A_ST, 8'h01);
        repeat (20) @(posedge clk);
        rd(A_ST, 32'h00);
        rd(A_CNT, 32'h00);
        wr(A_CNT, 8'h02);
        repeat (10) @(posedge clk);
        wr(A_MSK, 8'h00);
        irq_chk(1'b0);
        wr(A_MSK, 8'h01);
        irq_chk(1'b1);
        wr(A_ST, 8'h01);
        irq_chk(1'b0);
        s_axi_wstrb <= 4'h0;
        wr(A_MSK, 8'h00);
        s_axi_wstrb <= 4'hF;
        rd(A_MSK, 32'h01);
        wr(A_CT1, 8'h00);
        wr(A_HI, 8'h11);
        wr(A_CNT, 8'h50);
        wr(A_DUTY, 8'h60);
        rd(A_CNT, 32'h50);
        wr(A_CT1, 8'h80);
        pin_chk(1'b1, 1'b1);
        wr(A_CT1, 8'hC0);
        pin_chk(1'b0, 1'b1);
        wr(A_DUTY, 8'h40);
        pin_chk(1'b1, 1'b1);
        wr(A_CT1, 8'h80);
        pin_chk(1'b0, 1'b1);
        wr(A_CT1, 8'h00);
        gpio_out <= 1'b1;
        gpio_oe <= 1'b1;
        pin_chk(1'b1, 1'b1);
        gpio_out <= 1'b0;
        gpio_oe <= 1'b0;
        pin_chk(1'b0, 1'b0);
        // Reset again while counting
        wr(A_CT1, 8'h81);
        sys_rst <= 1'b1;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rd(A_CT1, 32'h00);
        rd(A_CT2, 32'h3F);
        rd(A_PS, 32'hFF);
        rd(A_ST, 32'h00);
        irq_chk(1'b0);
        pin_chk(1'b0, 1'b0);
        end_sim();
    end
endmodule

// ### rtl/dtp_pkg.sv
package dtp_pkg;
    localparam int          CNT_W          = 10;
    localparam int          ADDR_W         = 8;
    // Register indices; byte address is four times the index
    localparam logic [2:0]  IDX_COUNT      = 3'h0;
    localparam logic [2:0]  IDX_CTRL_ONE   = 3'h1;
    localparam logic [2:0]  IDX_CTRL_TWO   = 3'h2;
    localparam logic [2:0]  IDX_DUTY_LOW   = 3'h3;
    localparam logic [2:0]  IDX_PS_COUNT   = 3'h4;
    localparam logic [2:0]  IDX_HIGH_BITS  = 3'h5;
    localparam logic [2:0]  IDX_IRQ_STAT   = 3'h6;
    localparam logic [2:0]  IDX_IRQ_MASK   = 3'h7;
    // timer_control_one fields
    localparam int          B_RUN_EN       = 0;
    localparam int          B_RELOAD_SEL   = 1;
    localparam int          B_ONE_SHOT     = 2;
    localparam int          B_PWM_POL      = 6;
    localparam int          B_PWM_OE       = 7;
    // timer_control_two fields
    localparam int          B_RATE_LO      = 0;
    localparam int          B_PS_EN_N      = 3;
    localparam int          B_EDGE_SEL     = 4;
    localparam int          B_CLK_SRC      = 5;
    // shared_high_bits fields, then the underflow bit of the irq status register
    localparam int          B_RELOAD_HI    = 4;
    localparam int          B_DUTY_HI      = 0;
    localparam int          B_UNDERFLOW    = 0;
    localparam logic [9:0]  FULL_SCALE     = 10'h3FF;
    localparam logic [9:0]  RST_COUNT      = 10'h000;
    localparam logic [7:0]  RST_CTRL_ONE   = 8'h00;
    localparam logic [7:0]  RST_CTRL_TWO   = 8'h3F;
    localparam logic [7:0]  RST_PS_COUNT   = 8'hFF;
    localparam logic [7:0]  RST_BYTE       = 8'h00;
    localparam logic [7:0]  CTRL_ONE_MASK  = 8'hC7;
    localparam logic [7:0]  CTRL_TWO_MASK  = 8'h3F;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage

// ### rtl/dtp_timer.sv
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
// Summary of operation
// - Ten-bit down counter; count register read returns its present low byte.
// - Count write loads reload and counter with byte plus high bits 5:4.
// - Counter moves only while the run-enable bit is one.
// - Non-stop, reload-select zero: underflow loads full scale 0x3FF.
// - Non-stop, reload-select one: underflow loads stored reload value.
// - One-shot counts down to zero once, then halts.
// - Polarity bit one makes PWM active low, zero active high.
// - PWM enable bit routes PWM to the port pin, else plain GPIO.
// - Rate code 000 divides by 2, each step doubles, up to 256.
// - Prescaler enable bit is active low; one bypasses the prescaler.
// - External clock counts on falling edge if edge-select is one.
// - Clock-source bit one picks external pin, zero instruction clock.
// - PWM frame period is the ten-bit reload value plus one ticks if reload-select is one, else 1024 ticks.
// - PWM duty is ten bits: high bits 1:0 and duty low byte.
// - Prescaler count register reads the live eight-bit prescaler.
module dtp_timer (
    input  wire logic                clk,
    input  wire logic                sys_rst,
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire logic                external_clock_pin,
    input  wire logic                gpio_out,
    input  wire logic                gpio_oe,
    output logic                     pwm_port_pin_out,
    output logic                     pwm_port_pin_oe,
    output logic                     irq
);

    typedef struct packed {
        logic       aw_rdy;
        logic       aw_full;
        logic [7:0] aw_addr;
        logic       w_rdy;
        logic       w_full;
        logic [7:0] w_byte;
        logic       w_lane;
        logic       bvalid;
        logic [1:0] bresp;
        logic       ar_rdy;
        logic       rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic [7:0] ctrl_one;
        logic [7:0] ctrl_two;
        logic [7:0] high_bits;
        logic [7:0] duty_low;
        logic [9:0] reload;
        logic [9:0] count;
        logic       halted;
        logic [7:0] ps_count;
        logic       ext_s1;
        logic       ext_s2;
        logic       ext_prev;
        logic [7:0] irq_stat;
        logic [7:0] irq_mask;
        logic       pin_out;
        logic       pin_oe;
        logic       irq;
    } dtp_state_s;

    dtp_state_s state_q;
    dtp_state_s state_d;

    logic       do_write;
    logic [2:0] w_idx;
    logic       w_ok;
    logic [2:0] r_idx;
    logic       r_ok;
    logic [7:0] r_val;
    logic       ext_edge;
    logic       src_tick;
    logic [7:0] ps_mask;
    logic       tmr_tick;
    logic       underflow;
    logic [9:0] duty;
    logic       pwm_active;
    logic       pwm_level;
    logic [7:0] wr;

    ////////////////////////////////////////////////////////////////////////
    // Clock path
    always_comb begin
        ext_edge = state_q.ctrl_two[dtp_pkg::B_EDGE_SEL] ?
                   (state_q.ext_prev & ~state_q.ext_s2) :
                   (~state_q.ext_prev & state_q.ext_s2);
        src_tick = state_q.ctrl_two[dtp_pkg::B_CLK_SRC] ? ext_edge
                                                         : 1'b1;
        ps_mask  = 8'hFF >> (3'h7 - state_q.ctrl_two[2:0]);
        tmr_tick = state_q.ctrl_two[dtp_pkg::B_PS_EN_N] ? src_tick :
                   (src_tick & ((state_q.ps_count & ps_mask) == ps_mask));
        underflow = state_q.ctrl_one[dtp_pkg::B_RUN_EN] & ~state_q.halted
                    & tmr_tick & (state_q.count == 10'h000);
        duty       = {state_q.high_bits[dtp_pkg::B_DUTY_HI +: 2],
                      state_q.duty_low};
        pwm_active = (state_q.count <= duty);
        pwm_level  = pwm_active ^ state_q.ctrl_one[dtp_pkg::B_PWM_POL];
    end

    ////////////////////////////////////////////////////////////////////////
    // Register decode
    always_comb begin
        do_write = state_q.aw_full & state_q.w_full & ~state_q.bvalid;
        w_idx    = state_q.aw_addr[4:2];
        w_ok     = (state_q.aw_addr[7:5] == 3'h0)
                   && (state_q.aw_addr[1:0] == 2'h0);
        r_idx    = s_axi_araddr[4:2];
        r_ok     = (s_axi_araddr[7:5] == 3'h0)
                   && (s_axi_araddr[1:0] == 2'h0);
        wr       = state_q.w_byte;
        case (r_idx)
            dtp_pkg::IDX_COUNT:     r_val = state_q.count[7:0];
            dtp_pkg::IDX_CTRL_ONE:  r_val = state_q.ctrl_one;
            dtp_pkg::IDX_CTRL_TWO:  r_val = state_q.ctrl_two;
            dtp_pkg::IDX_DUTY_LOW:  r_val = 8'h00;
            dtp_pkg::IDX_PS_COUNT:  r_val = state_q.ps_count;
            dtp_pkg::IDX_HIGH_BITS: r_val = state_q.high_bits;
            dtp_pkg::IDX_IRQ_STAT:  r_val = state_q.irq_stat;
            dtp_pkg::IDX_IRQ_MASK:  r_val = state_q.irq_mask;
            default:                r_val = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        state_d = state_q;
        // Pin synchroniser
        state_d.ext_s1   = external_clock_pin;
        state_d.ext_s2   = state_q.ext_s1;
        state_d.ext_prev = state_q.ext_s2;

        // Write address and data taken independently
        if (s_axi_awvalid && state_q.aw_rdy) begin
            state_d.aw_full = 1'b1;
            state_d.aw_addr = s_axi_awaddr;
            state_d.aw_rdy  = 1'b0;
        end
        if (s_axi_wvalid && state_q.w_rdy) begin
            state_d.w_full = 1'b1;
            state_d.w_byte = s_axi_wdata[7:0];
            state_d.w_lane = s_axi_wstrb[0];
            state_d.w_rdy  = 1'b0;
        end
        if (do_write) begin
            state_d.bvalid  = 1'b1;
            state_d.bresp   = w_ok ? dtp_pkg::RESP_OKAY
                                   : dtp_pkg::RESP_SLVERR;
            state_d.aw_full = 1'b0;
            state_d.w_full  = 1'b0;
        end
        if (state_q.bvalid && s_axi_bready) begin
            state_d.bvalid = 1'b0;
            state_d.aw_rdy = 1'b1;
            state_d.w_rdy  = 1'b1;
        end

        // Read channel
        if (s_axi_arvalid && state_q.ar_rdy) begin
            state_d.ar_rdy = 1'b0;
            state_d.rvalid = 1'b1;
            state_d.rdata  = r_ok ? r_val : 8'h00;
            state_d.rresp  = r_ok ? dtp_pkg::RESP_OKAY
                                  : dtp_pkg::RESP_SLVERR;
        end
        if (state_q.rvalid && s_axi_rready) begin
            state_d.rvalid = 1'b0;
            state_d.ar_rdy = 1'b1;
        end

        // Prescaler advances only when inserted
        if (!state_q.ctrl_two[dtp_pkg::B_PS_EN_N] && src_tick) begin
            state_d.ps_count = state_q.ps_count + 8'h01;
        end

        // Counter
        if (state_q.ctrl_one[dtp_pkg::B_RUN_EN] && !state_q.halted
            && tmr_tick) begin
            if (state_q.count != 10'h000) begin
                state_d.count = state_q.count - 10'h001;
            end else if (state_q.ctrl_one[dtp_pkg::B_ONE_SHOT]) begin
                state_d.halted = 1'b1;
            end else if (state_q.ctrl_one[dtp_pkg::B_RELOAD_SEL]) begin
                state_d.count = state_q.reload;
            end else begin
                state_d.count = dtp_pkg::FULL_SCALE;
            end
        end

        // Sticky flag, set wins over clear
        if (do_write && w_ok && state_q.w_lane
            && w_idx == dtp_pkg::IDX_IRQ_STAT) begin
            state_d.irq_stat = state_q.irq_stat & ~wr;
        end
        if (underflow) begin
            state_d.irq_stat[dtp_pkg::B_UNDERFLOW] = 1'b1;
        end

        // Register writes
        if (do_write && w_ok && state_q.w_lane) begin
            case (w_idx)
                dtp_pkg::IDX_COUNT: begin
                    state_d.reload = {state_q.high_bits[
                                      dtp_pkg::B_RELOAD_HI +: 2], wr};
                    state_d.count  = {state_q.high_bits[
                                      dtp_pkg::B_RELOAD_HI +: 2], wr};
                    state_d.halted = 1'b0;
                end
                dtp_pkg::IDX_CTRL_ONE: begin
                    state_d.ctrl_one = wr & dtp_pkg::CTRL_ONE_MASK;
                    if (!wr[dtp_pkg::B_RUN_EN]) begin
                        state_d.halted = 1'b0;
                    end
                end
                dtp_pkg::IDX_CTRL_TWO:
                    state_d.ctrl_two = wr & dtp_pkg::CTRL_TWO_MASK;
                dtp_pkg::IDX_DUTY_LOW:  state_d.duty_low  = wr;
                dtp_pkg::IDX_HIGH_BITS: state_d.high_bits = wr;
                dtp_pkg::IDX_IRQ_MASK:  state_d.irq_mask  = wr;
                default: ;
            endcase
        end

        // Pin and interrupt outputs
        if (state_q.ctrl_one[dtp_pkg::B_PWM_OE]) begin
            state_d.pin_out = pwm_level;
            state_d.pin_oe  = 1'b1;
        end else begin
            state_d.pin_out = gpio_out;
            state_d.pin_oe  = gpio_oe;
        end
        state_d.irq = |(state_d.irq_stat & state_d.irq_mask);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q          <= '0;
            state_q.aw_rdy   <= 1'b1;
            state_q.w_rdy    <= 1'b1;
            state_q.ar_rdy   <= 1'b1;
            state_q.ctrl_one <= dtp_pkg::RST_CTRL_ONE;
            state_q.ctrl_two <= dtp_pkg::RST_CTRL_TWO;
            state_q.ps_count <= dtp_pkg::RST_PS_COUNT;
            state_q.count    <= dtp_pkg::RST_COUNT;
            state_q.reload   <= dtp_pkg::RST_COUNT;
            state_q.high_bits <= dtp_pkg::RST_BYTE;
            state_q.duty_low <= dtp_pkg::RST_BYTE;
        end else begin
            state_q <= state_d;
        end
    end

    always_comb begin
        s_axi_awready    = state_q.aw_rdy;
        s_axi_wready     = state_q.w_rdy;
        s_axi_bvalid     = state_q.bvalid;
        s_axi_bresp      = state_q.bresp;
        s_axi_arready    = state_q.ar_rdy;
        s_axi_rvalid     = state_q.rvalid;
        s_axi_rdata      = {24'h000000, state_q.rdata};
        s_axi_rresp      = state_q.rresp;
        pwm_port_pin_out = state_q.pin_out;
        pwm_port_pin_oe  = state_q.pin_oe;
        irq              = state_q.irq;
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    logic cnt_wr;
    assign cnt_wr = do_write && w_ok && state_q.w_lane
                    && w_idx == dtp_pkg::IDX_COUNT;

    a_full_reload: assert property (underflow && !cnt_wr
        && !state_q.ctrl_one[2] && !state_q.ctrl_one[1]
        |=> state_q.count == 10'h3FF)
        else $error("full scale not loaded on underflow");
    a_value_reload: assert property (underflow && !cnt_wr
        && !state_q.ctrl_one[2] && state_q.ctrl_one[1]
        |=> state_q.count == $past(state_q.reload))
        else $error("reload value not loaded on underflow");
    a_one_shot_halt: assert property (underflow && !cnt_wr
        && !(do_write && w_idx == dtp_pkg::IDX_CTRL_ONE)
        && state_q.ctrl_one[2] |=> state_q.halted ##1
        (state_q.count == 10'h000 || $past(cnt_wr)))
        else $error("one-shot did not halt at zero");
    a_stop_disabled: assert property (!state_q.ctrl_one[0] && !cnt_wr
        |=> $stable(state_q.count))
        else $error("counter moved while disabled");
    a_count_write: assert property (cnt_wr
        |=> state_q.count == {$past(state_q.high_bits[5:4]),
                              $past(state_q.w_byte)})
        else $error("count write did not load counter");
    a_pwm_pin: assert property (state_q.ctrl_one[7]
        |=> pwm_port_pin_oe && pwm_port_pin_out ==
            (($past(state_q.count) <= $past(duty))
             ^ $past(state_q.ctrl_one[6])))
        else $error("pwm pin level wrong");
    a_gpio_pass: assert property (!state_q.ctrl_one[7]
        |=> pwm_port_pin_out == $past(gpio_out)
            && pwm_port_pin_oe == $past(gpio_oe))
        else $error("gpio not passed through");
    a_flag_set: assert property (underflow
        |=> state_q.irq_stat[0])
        else $error("underflow flag not set");
    a_ps_bypass: assert property (state_q.ctrl_two[3]
        && !(do_write && w_idx == dtp_pkg::IDX_CTRL_TWO)
        |=> $stable(state_q.ps_count))
        else $error("prescaler moved while bypassed");
    // Inserted prescaler steps once per source tick
    a_ps_step: assert property (!state_q.ctrl_two[3] && src_tick
        |=> state_q.ps_count == $past(state_q.ps_count) + 8'h01)
        else $error("prescaler did not advance");
    a_irq_level: assert property (irq ==
        |(state_q.irq_stat & state_q.irq_mask))
        else $error("interrupt level wrong");

    c_underflow_reload: cover property (underflow && state_q.ctrl_one[1]);
    c_one_shot: cover property (underflow && state_q.ctrl_one[2]);
    c_ext_tick: cover property (state_q.ctrl_two[5] && tmr_tick);
    c_irq: cover property (irq);

endmodule
